// [src/rss_pkg.sv]
// Constants and types for the regulator start-up sequencer
// How it works
// - Hold reset until supplies and oscillator good
// - Copy whole config memory after reset
// - Bus reconfiguration allowed after load, any enable
// - Default start needs enable, input rail, load, address
// - Software enable options replace pin enable
// - Switching frequency setting 150 to 1500 kHz
// - Three select pins choose one of eight voltages
// - Address strap offset 0..15 added to bases
// - Select pins index entries 77h to 7Eh
// - Mode bit picks select pins or bus voltage
package rss_pkg;
  localparam int unsigned RSS_MEM_DEPTH = 128;
  localparam int unsigned RSS_AW = 7;
  localparam logic [6:0] RSS_VSEL_BASE = 7'h77;
  localparam logic [6:0] RSS_I2C_BASE = 7'h10;
  localparam logic [6:0] RSS_PMB_BASE = 7'h40;
  localparam logic [15:0] RSS_FSW_MIN_KHZ = 16'h0096;
  localparam logic [15:0] RSS_FSW_MAX_KHZ = 16'h05dc;
  localparam logic [15:0] RSS_FSW_RST_KHZ = 16'h0258;
  localparam logic [31:0] RSS_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] RSS_ADDR_FSW = 32'h0000_0004;
  localparam logic [31:0] RSS_ADDR_VOUT = 32'h0000_0008;
  localparam logic [31:0] RSS_ADDR_STAT = 32'h0000_000c;
  localparam logic [31:0] RSS_ADDR_MEMA = 32'h0000_0010;
  localparam logic [31:0] RSS_ADDR_MEMD = 32'h0000_0014;
  localparam int unsigned RSS_CTRL_VSEL_MODE = 0;
  localparam int unsigned RSS_CTRL_SW_EN_OPT = 1;
  localparam int unsigned RSS_CTRL_SW_ON = 2;
  localparam int unsigned RSS_CTRL_NO_OFFS = 3;
  localparam int unsigned RSS_ST_LOADED = 0;
  localparam int unsigned RSS_ST_ADDR_OK = 1;
  localparam int unsigned RSS_ST_CONV = 2;
  localparam int unsigned RSS_ST_READY = 3;
  localparam logic [1:0] RSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSS_RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    RSS_S_RESET = 5'h01,
    RSS_S_LOAD = 5'h02,
    RSS_S_ADDR = 5'h04,
    RSS_S_IDLE = 5'h08,
    RSS_S_CONV = 5'h10
  } rss_state_t;
endpackage : rss_pkg

// [src/rss_sequencer.sv]
// Regulator start-up sequencer with AXI4-Lite register access
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer #(
  parameter int unsigned SYNC_STAGES = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bias_supply_good,
  input wire logic core_supply_rail_good,
  input wire logic osc_stable,
  input wire logic enable_pin,
  input wire logic input_rail_good,
  input wire logic voltage_select_bit0,
  input wire logic voltage_select_bit1,
  input wire logic voltage_select_bit2,
  input wire logic adc_done,
  input wire logic [9:0] adc_code,
  output logic adc_start,
  output logic [rss_pkg::RSS_AW-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic conv_enable,
  output logic seq_ready,
  output logic [7:0] vout_code,
  output logic [15:0] fsw_khz,
  output logic [6:0] i2c_addr,
  output logic [6:0] pmbus_addr,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rss_pkg::*;

  initial begin
    if (SYNC_STAGES != 3) $error("SYNC_STAGES must be 3");
  end

  // Pin synchronisers: s1 only feeds s2; change counted once s2 and s3 agree
  logic [8:0] pin_in, s1_r, s2_r, s3_r, flt_r;
  assign pin_in = {voltage_select_bit2, voltage_select_bit1, voltage_select_bit0, input_rail_good,
                   enable_pin, osc_stable, core_supply_rail_good, bias_supply_good, adc_done};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      s3_r <= 9'h000;
      flt_r <= 9'h000;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
    end
  end
  logic adc_done_s, bias_ok, core_ok, osc_ok, en_ok, rail_ok;
  logic [2:0] vsel_s;
  assign {vsel_s, rail_ok, en_ok, osc_ok, core_ok, bias_ok, adc_done_s} = flt_r;
  logic por_ok;
  assign por_ok = bias_ok & core_ok & osc_ok;

  rss_state_t state_r, state_nxt;
  logic [RSS_AW:0] ld_cnt_r;
  logic ld_pend_r;
  logic [7:0] cfg_mem [RSS_MEM_DEPTH];
  logic loaded, addr_ok;
  logic [3:0] offs_r;
  logic [3:0] ctrl_r;
  logic [15:0] fsw_r;
  logic [7:0] vbus_r;
  logic [6:0] mema_r;
  logic run_cond;

  assign loaded = (state_r == RSS_S_IDLE) || (state_r == RSS_S_CONV) || (state_r == RSS_S_ADDR);
  assign addr_ok = (state_r == RSS_S_IDLE) || (state_r == RSS_S_CONV);
  assign run_cond = addr_ok & (ctrl_r[RSS_CTRL_SW_EN_OPT] ? ctrl_r[RSS_CTRL_SW_ON] : en_ok)
                    & rail_ok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSS_S_RESET: if (por_ok) state_nxt = RSS_S_LOAD;
      // Counter stops with its top bit set; leave once the last word is written
      RSS_S_LOAD: if (ld_cnt_r[RSS_AW] && !ld_pend_r) state_nxt = RSS_S_ADDR;
      RSS_S_ADDR: if (adc_done_s) state_nxt = RSS_S_IDLE;
      RSS_S_IDLE: if (run_cond) state_nxt = RSS_S_CONV;
      RSS_S_CONV: if (!run_cond) state_nxt = RSS_S_IDLE;
      default: state_nxt = RSS_S_RESET;
    endcase
    if (!por_ok) state_nxt = RSS_S_RESET;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state_r <= RSS_S_RESET;
    else state_r <= state_nxt;
  end

  // Load walks every word; memory read has one cycle latency
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != RSS_S_LOAD) begin
      ld_cnt_r <= '0;
      ld_pend_r <= 1'b0;
    end else if (!ld_cnt_r[RSS_AW]) begin
      ld_cnt_r <= ld_cnt_r + (RSS_AW+1)'(1);
      ld_pend_r <= 1'b1;
    end else begin
      ld_pend_r <= 1'b0;
    end
  end
  logic [RSS_AW-1:0] ld_wr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) ld_wr_r <= '0;
    else ld_wr_r <= ld_cnt_r[RSS_AW-1:0];
  end
  assign mem_rd_addr = ld_cnt_r[RSS_AW-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) adc_start <= 1'b0;
    else adc_start <= (state_r == RSS_S_LOAD) && (state_nxt == RSS_S_ADDR);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) offs_r <= 4'h0;
    else if (state_r == RSS_S_ADDR && adc_done_s) offs_r <= adc_code[9:6];
  end

  // AXI4-Lite slave, one outstanding each way
  logic aw_got_r, w_got_r;
  logic [31:0] awa_r, wd_r;
  logic [3:0] ws_r;
  logic wr_go, wr_hit, ar_hit;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_hit = awa_r == RSS_ADDR_CTRL || awa_r == RSS_ADDR_FSW || awa_r == RSS_ADDR_VOUT ||
                  awa_r == RSS_ADDR_MEMA || awa_r == RSS_ADDR_MEMD;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RSS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awa_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit && loaded) ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wr_ok;
  assign wr_ok = wr_go && loaded;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 4'h0;
      fsw_r <= RSS_FSW_RST_KHZ;
      vbus_r <= 8'h00;
      mema_r <= 7'h00;
    end else if (wr_ok) begin
      if (awa_r == RSS_ADDR_CTRL && ws_r[0]) ctrl_r <= wd_r[3:0];
      if (awa_r == RSS_ADDR_FSW && ws_r[1:0] == 2'h3 && wd_r[15:0] >= RSS_FSW_MIN_KHZ &&
          wd_r[15:0] <= RSS_FSW_MAX_KHZ) fsw_r <= wd_r[15:0];
      if (awa_r == RSS_ADDR_VOUT && ws_r[0]) vbus_r <= wd_r[7:0];
      if (awa_r == RSS_ADDR_MEMA && ws_r[0]) mema_r <= wd_r[6:0];
    end
  end

  // Working copy of config memory; bus may patch an entry after load
  always_ff @(posedge aclk) begin
    if (ld_pend_r && state_r == RSS_S_LOAD) cfg_mem[ld_wr_r] <= mem_rd_data;
    else if (wr_ok && awa_r == RSS_ADDR_MEMD && ws_r[0]) cfg_mem[mema_r] <= wd_r[7:0];
  end

  logic [31:0] rd_mux;
  always_comb begin
    ar_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      RSS_ADDR_CTRL: rd_mux = {28'h0, ctrl_r};
      RSS_ADDR_FSW: rd_mux = {16'h0, fsw_r};
      RSS_ADDR_VOUT: rd_mux = {24'h0, vout_code};
      RSS_ADDR_STAT: rd_mux = {20'h0, offs_r, 4'h0, seq_ready, conv_enable, addr_ok, loaded};
      RSS_ADDR_MEMA: rd_mux = {25'h0, mema_r};
      RSS_ADDR_MEMD: rd_mux = {24'h0, cfg_mem[mema_r]};
      default: ar_hit = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= ar_hit ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Outputs
  logic [2:0] vsel_idx;
  assign vsel_idx = vsel_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_enable <= 1'b0;
      seq_ready <= 1'b0;
      vout_code <= 8'h00;
      fsw_khz <= RSS_FSW_RST_KHZ;
      i2c_addr <= RSS_I2C_BASE;
      pmbus_addr <= RSS_PMB_BASE;
    end else begin
      conv_enable <= (state_nxt == RSS_S_CONV);
      seq_ready <= addr_ok;
      vout_code <= ctrl_r[RSS_CTRL_VSEL_MODE] ? cfg_mem[RSS_VSEL_BASE + {4'h0, vsel_idx}]
                                                : vbus_r;
      fsw_khz <= fsw_r;
      i2c_addr <= RSS_I2C_BASE + (ctrl_r[RSS_CTRL_NO_OFFS] ? 7'h00 : {3'h0, offs_r});
      pmbus_addr <= RSS_PMB_BASE + (ctrl_r[RSS_CTRL_NO_OFFS] ? 7'h00 : {3'h0, offs_r});
    end
  end

  a_conv_needs_all: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_enable |-> $past(addr_ok) && $past(rail_ok)) else $error("conversion without start conditions");
  a_conv_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == RSS_S_CONV && !run_cond) |=> !conv_enable) else $error("conversion not stopped");
  a_por_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !por_ok |=> state_r == RSS_S_RESET) else $error("left reset with bad supply");
  a_no_early_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !loaded) |=> s_axi_bresp == RSS_RESP_SLVERR) else $error("write accepted before load");
  a_fsw_range: assert property (@(posedge aclk) disable iff (!aresetn)
    fsw_r >= RSS_FSW_MIN_KHZ && fsw_r <= RSS_FSW_MAX_KHZ) else $error("frequency out of range");
  a_sw_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[RSS_CTRL_SW_EN_OPT] && !ctrl_r[RSS_CTRL_SW_ON]) |=> !conv_enable) else $error("software off ignored");
  a_load_first: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(addr_ok) |-> $past(state_r) == RSS_S_ADDR) else $error("ready without address");
  a_addr_offs: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[RSS_CTRL_NO_OFFS] ##1 !ctrl_r[RSS_CTRL_NO_OFFS] |-> pmbus_addr == RSS_PMB_BASE + {3'h0, $past(offs_r)})
    else $error("bus address offset wrong");
endmodule : rss_sequencer
`default_nettype wire

// [tb/rss_far_model.sv]
// Far side model: configuration memory and address strap converter
`timescale 1ns/10ps
`default_nettype none
module rss_far_model #(
  parameter logic [9:0] STRAP_CODE = 10'h2c5
) (
  input wire logic aclk,
  input wire logic adc_start,
  output logic adc_done,
  output logic [9:0] adc_code,
  input wire logic [6:0] mem_rd_addr,
  output logic [7:0] mem_rd_data
);
  int cnt = 0;
  // One cycle read latency, contents are a known pattern per index
  always_ff @(posedge aclk) begin
    mem_rd_data <= {1'b0, mem_rd_addr} ^ 8'ha5;
    if (adc_start) cnt <= 8;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // Done held for five cycles so the synchroniser sees it
  assign adc_done = (cnt != 0) && (cnt < 6);
  // Result only valid while done; garbage otherwise
  assign adc_code = adc_done ? STRAP_CODE : ~STRAP_CODE;
endmodule : rss_far_model
`default_nettype wire

// [tb/rss_sequencer_tb.sv]
// Self-checking bench for the regulator start-up sequencer
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer_tb;
  import rss_pkg::*;
  logic aclk, aresetn, bias_supply_good, core_supply_rail_good, osc_stable, enable_pin, input_rail_good;
  logic voltage_select_bit0, voltage_select_bit1, voltage_select_bit2, adc_done, adc_start, conv_enable, seq_ready;
  logic [9:0] adc_code;
  logic [6:0] mem_rd_addr, i2c_addr, pmbus_addr;
  logic [7:0] mem_rd_data, vout_code;
  logic [15:0] fsw_khz;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int tests_run = 0;
  rss_sequencer uut (.aclk, .aresetn, .bias_supply_good, .core_supply_rail_good, .osc_stable, .enable_pin,
    .input_rail_good, .voltage_select_bit0, .voltage_select_bit1, .voltage_select_bit2, .adc_done, .adc_code,
    .adc_start, .mem_rd_addr, .mem_rd_data, .conv_enable, .seq_ready, .vout_code, .fsw_khz, .i2c_addr,
    .pmbus_addr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rss_far_model far (.aclk, .adc_start, .adc_done, .adc_code, .mem_rd_addr, .mem_rd_data);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  function automatic logic [7:0] cfg(input int i);
    return 8'(i) ^ 8'ha5;
  endfunction : cfg
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Synchronisers add a few cycles, so pins settle before sampling
  task automatic settle;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  task automatic wait_ready;
    for (int i = 0; i < 400 && seq_ready !== 1'b1; i++) @(negedge aclk);
    settle;
  endtask : wait_ready
  // Handshakes are judged on settled values half a cycle before the edge that takes them
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    n = 0;
    b_t = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = (s_axi_bvalid === 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t && n < 50);
    s_axi_bready <= 1'b0;
    if (!b_t) fails++;
    chk("bresp", 32'(resp), 32'(er));
  endtask : wr
  task automatic rdr(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    logic ar_t, r_t;
    logic [31:0] rd;
    logic [1:0] rp;
    n = 0;
    r_t = 1'b0;
    rd = '0;
    rp = 2'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rp = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t && n < 50);
    s_axi_rready <= 1'b0;
    if (!r_t) fails++;
    chk("rdata", rd, exp);
    chk("rresp", 32'(rp), 32'(er));
  endtask : rdr
  initial begin
    logic [15:0] fv[4] = '{16'h05dc, 16'h05dd, 16'h0096, 16'h0095};
    logic [15:0] fe[4] = '{16'h05dc, 16'h05dc, 16'h0096, 16'h0096};
    int mi[3] = '{0, 64, 127};
    {aresetn, osc_stable, enable_pin, input_rail_good} = 4'h0;
    {bias_supply_good, core_supply_rail_good} = 2'h3;
    {voltage_select_bit2, voltage_select_bit1, voltage_select_bit0} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    chk("fsw_khz", 32'(fsw_khz), 32'(RSS_FSW_RST_KHZ));
    wr(RSS_ADDR_VOUT, 32'h33, RSS_RESP_SLVERR);
    @(posedge aclk);
    enable_pin <= 1'b1;
    input_rail_good <= 1'b1;
    settle;
    chk("seq_ready", 32'(seq_ready), 32'h0);
    chk("conv_enable", 32'(conv_enable), 32'h0);
    @(posedge aclk);
    osc_stable <= 1'b1;
    wait_ready;
    chk("conv_enable", 32'(conv_enable), 32'h1);
    chk("i2c_addr", 32'(i2c_addr), 32'h1b);
    chk("pmbus_addr", 32'(pmbus_addr), 32'h4b);
    rdr(RSS_ADDR_STAT, 32'h0b0f, RSS_RESP_OKAY);
    @(posedge aclk);
    input_rail_good <= 1'b0;
    settle;
    chk("conv_enable", 32'(conv_enable), 32'h0);
    @(posedge aclk);
    input_rail_good <= 1'b1;
    enable_pin <= 1'b0;
    settle;
    chk("conv_enable", 32'(conv_enable), 32'h0);
    foreach (mi[k]) begin
      wr(RSS_ADDR_MEMA, mi[k], RSS_RESP_OKAY);
      rdr(RSS_ADDR_MEMD, 32'(cfg(mi[k])), RSS_RESP_OKAY);
    end
    wr(RSS_ADDR_VOUT, 32'h42, RSS_RESP_OKAY);
    @(negedge aclk);
    chk("vout_code", 32'(vout_code), 32'h42);
    foreach (fv[k]) begin
      wr(RSS_ADDR_FSW, 32'(fv[k]), RSS_RESP_OKAY);
      @(negedge aclk);
      chk("fsw_khz", 32'(fsw_khz), 32'(fe[k]));
    end
    wr(RSS_ADDR_CTRL, 32'h1, RSS_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      {voltage_select_bit2, voltage_select_bit1, voltage_select_bit0} <= 3'(i);
      settle;
      chk("vout_code", 32'(vout_code), 32'(cfg(32'h77 + i)));
    end
    rdr(RSS_ADDR_STAT, 32'h0b0b, RSS_RESP_OKAY);
    wr(RSS_ADDR_CTRL, 32'h2, RSS_RESP_OKAY);
    @(posedge aclk);
    enable_pin <= 1'b1;
    settle;
    chk("conv_enable", 32'(conv_enable), 32'h0);
    wr(RSS_ADDR_CTRL, 32'h6, RSS_RESP_OKAY);
    @(posedge aclk);
    enable_pin <= 1'b0;
    settle;
    chk("conv_enable", 32'(conv_enable), 32'h1);
    wr(RSS_ADDR_CTRL, 32'h8, RSS_RESP_OKAY);
    settle;
    chk("i2c_addr", 32'(i2c_addr), 32'h10);
    rdr(32'h0000_0040, 32'h0, RSS_RESP_SLVERR);
    wr(RSS_ADDR_STAT, 32'h0, RSS_RESP_SLVERR);
    @(posedge aclk);
    core_supply_rail_good <= 1'b0;
    settle;
    chk("seq_ready", 32'(seq_ready), 32'h0);
    @(posedge aclk);
    core_supply_rail_good <= 1'b1;
    wait_ready;
    chk("seq_ready", 32'(seq_ready), 32'h1);
    end_sim;
  end
  // Whole sequence runs well under this span
  initial begin
    repeat (8000) @(posedge aclk);
    fails++;
    end_sim;
  end
endmodule : rss_sequencer_tb
`default_nettype wire
